// *** core/jtap_regs.svh ***
// Purpose: Constants of the test access port.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef JTAP_REGS_SVH
`define JTAP_REGS_SVH

// ==========================================================
// Instruction register
`define JTAP_IR_LEN 4
`define JTAP_IR_EXTEST 4'h0
`define JTAP_IR_SAMPLE 4'h1
`define JTAP_IR_BYPASS 4'hF
`define JTAP_IR_CAPTURE 4'h5

// ==========================================================
// Boundary scan and reset sequence
`define JTAP_BSR_PINS 8
`define JTAP_RESET_TMS 3'h5
`define JTAP_TMS_CNT_MAX 3'h7

`endif

// *** core/jtap_pkg.sv ***
// Purpose: Types of the test access port.
// Assumes: Nothing.
// Notes:   State names follow the standard controller graph.
`default_nettype none

package jtap_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtap_state_t;
endpackage

`default_nettype wire

// *** core/jtap_sync.sv ***
// Purpose: Two-flop synchroniser for a group of level inputs.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes:   First stage feeds only the second stage.
`default_nettype none

module jtap_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

`default_nettype wire

// *** core/jtap_bsr.sv ***
// Purpose: Boundary-scan chain with parallel update latch.
// Assumes: Strobes are one-cycle pulses on sys_clk.
// Notes:   Low cells watch pins, high cells watch core outputs.
`default_nettype none
`include "jtap_regs.svh"

module jtap_bsr import jtap_pkg::*; #(
  parameter int N = `JTAP_BSR_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Strobes
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  // Serial path
  input wire logic sin,
  output logic sout,
  // Parallel sides
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] core_out,
  output logic [N-1:0] upd_q
);
  logic [2*N-1:0] cell_q;
  logic [2*N-1:0] cap_val;
  logic [2*N:0] chain;

  assign cap_val = {core_out, pin_in};
  assign chain = {sin, cell_q};
  assign sout = cell_q[0];

  // ==========================================================
  // Scan cells
  for (genvar i = 0; i < 2 * N; i++) begin : g_cell
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        cell_q[i] <= 1'b0;
      end else if (capture) begin
        cell_q[i] <= cap_val[i];
      end else if (shift) begin
        cell_q[i] <= chain[i+1];
      end
    end
  end

  // ==========================================================
  // Update latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      upd_q <= '0;
    end else if (update) begin
      upd_q <= cell_q[2*N-1:N];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  upd_stable_a: assert property (!update |=> $stable(upd_q))
    else $error("update latch moved without update");
  upd_load_a: assert property (
    update |=> upd_q == $past(cell_q[2*N-1:N]))
    else $error("update latch missed shifted value");
endmodule

`default_nettype wire

// *** core/jtap_tap.sv ***
// Purpose: Boundary-scan test access port with controller,
//          instruction register, bypass and boundary registers.
// Assumes: sys_clk is far faster than tck; link pins are async.
// Notes:   Test logic steps on tck edges that sys_clk finds.
// Function
// - Port has tck, tms, tdi inputs and a tdo output.
// - Test reset low forces the controller to reset without tck.
// - All test logic advances only on edges of the test clock.
// - Instructions and data enter serially on tdi, one bit a clock.
// - Controller decodes tms to pick the next operation.
// - Shifted instruction and data bits leave serially on tdo.
// - Bypass and boundary-scan data registers both exist.
// - Extra data registers are optional; none are relied upon.
// - Bypass is one stage from tdi to tdo.
// - Boundary register gives serial access to pins.
// - Active instruction picks the test and the data register.
// - Instruction shift path has at least two cells.
// - Controller is a synchronous machine stepped by tms at tck.
// - Five high tms clocks reach reset; high tms stays there.
// - Shift-DR moves the selected register one bit toward tdo.
// - Update-IR latches the instruction; latch steady while shifting.
// - Update-DR loads the parallel latch; latch steady while shifting.
`default_nettype none
`include "jtap_regs.svh"

module jtap_tap import jtap_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe_n,
  // Boundary pins
  input wire logic [`JTAP_BSR_PINS-1:0] pin_in,
  input wire logic [`JTAP_BSR_PINS-1:0] core_out,
  output logic [`JTAP_BSR_PINS-1:0] pin_out,
  // Status
  output logic [`JTAP_IR_LEN-1:0] instr,
  output logic test_mode
);
  localparam int N = `JTAP_BSR_PINS;

  logic tck_s, tms_s, tdi_s, trst_s;
  logic [N-1:0] pin_s;
  logic tck_prev_q;
  logic tck_rise, tck_fall;
  jtap_state_t st_q, st_d;
  logic [`JTAP_IR_LEN-1:0] ir_sh_q, ir_q;
  logic byp_q;
  logic [2:0] tms_cnt_q;
  logic tdo_q, tdo_oe_n_q, test_mode_q;
  logic [N-1:0] pin_out_q, bsr_upd;
  logic bsr_sout;
  logic sel_bsr, sel_byp, is_extest;
  logic in_shift, dr_bit, tdo_d;
  logic bsr_cap, bsr_shift, bsr_upd_stb;

  // ==========================================================
  // Link synchronisers and edge finders
  jtap_sync #(.W(4), .INIT(4'h8)) u_link_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({trst_n, tdi, tms, tck}),
    .q({trst_s, tdi_s, tms_s, tck_s})
  );

  jtap_sync #(.W(N), .INIT('0)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pin_in),
    .q(pin_s)
  );

  // Same two flops on tms and tdi, so they line up with tck edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ==========================================================
  // Controller next state
  // Sixteen states, every code legal, so no default
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RESET: st_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Test reset wins over any tck edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !trst_s) begin
      st_q <= ST_RESET;
    end else if (tck_rise) begin
      st_q <= st_d;
    end
  end

  // Consecutive high tms count, for checking the reset path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tms_cnt_q <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_cnt_q <= 3'h0;
      end else if (tms_cnt_q != `JTAP_TMS_CNT_MAX) begin
        tms_cnt_q <= tms_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // Instruction register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ir_sh_q <= `JTAP_IR_CAPTURE;
    end else if (tck_rise && st_q == ST_CAP_IR) begin
      ir_sh_q <= `JTAP_IR_CAPTURE;
    end else if (tck_rise && st_q == ST_SHIFT_IR) begin
      ir_sh_q <= {tdi_s, ir_sh_q[`JTAP_IR_LEN-1:1]};
    end
  end

  // Active instruction loads at the tck fall in Update-IR; reset state and test reset restore bypass
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !trst_s || st_q == ST_RESET) begin
      ir_q <= `JTAP_IR_BYPASS;
    end else if (tck_fall && st_q == ST_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // ==========================================================
  // Data register selection
  // Unknown codes fall back to bypass
  assign is_extest = (ir_q == `JTAP_IR_EXTEST);
  assign sel_bsr = is_extest || (ir_q == `JTAP_IR_SAMPLE);
  assign sel_byp = ~sel_bsr;

  // Bypass stage captures zero, then passes tdi through
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byp_q <= 1'b0;
    end else if (tck_rise && sel_byp && st_q == ST_CAP_DR) begin
      byp_q <= 1'b0;
    end else if (tck_rise && sel_byp && st_q == ST_SHIFT_DR) begin
      byp_q <= tdi_s;
    end
  end

  assign bsr_cap = tck_rise && sel_bsr && st_q == ST_CAP_DR;
  assign bsr_shift = tck_rise && sel_bsr && st_q == ST_SHIFT_DR;
  assign bsr_upd_stb = tck_fall && sel_bsr && st_q == ST_UPD_DR;

  jtap_bsr #(.N(N)) u_bsr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .capture(bsr_cap),
    .shift(bsr_shift),
    .update(bsr_upd_stb),
    .sin(tdi_s),
    .sout(bsr_sout),
    .pin_in(pin_s),
    .core_out(core_out),
    .upd_q(bsr_upd)
  );

  // ==========================================================
  // Serial output
  assign in_shift = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);
  assign dr_bit = sel_bsr ? bsr_sout : byp_q;
  assign tdo_d = (st_q == ST_SHIFT_IR) ? ir_sh_q[0] : dr_bit;

  // tdo keeps its last bit outside shift; oe_n tells the probe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q <= in_shift ? tdo_d : tdo_q;
      tdo_oe_n_q <= ~in_shift;
    end
  end

  // ==========================================================
  // Pin and status outputs
  // Pins follow the core unless EXTEST drives them from the latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_out_q <= '0;
      test_mode_q <= 1'b0;
    end else begin
      pin_out_q <= is_extest ? bsr_upd : core_out;
      test_mode_q <= is_extest;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe_n = tdo_oe_n_q;
  assign pin_out = pin_out_q;
  assign instr = ir_q;
  assign test_mode = test_mode_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reset_entry_a: assert property (
    tms_cnt_q >= `JTAP_RESET_TMS |-> st_q == ST_RESET)
    else $error("five high tms clocks did not reach reset");
  trst_force_a: assert property (!trst_s |=> st_q == ST_RESET)
    else $error("test reset did not force reset state");
  state_hold_a: assert property (
    (!tck_rise && trst_s && st_q != ST_RESET) |=> $stable(st_q))
    else $error("state moved without tck rise");
  tms_step_a: assert property (
    (tck_rise && trst_s && st_q == ST_IDLE && tms_s) |=> st_q == ST_SEL_DR)
    else $error("tms high in idle did not select dr scan");
  bypass_path_a: assert property (
    (tck_rise && sel_byp && st_q == ST_SHIFT_DR) |=> byp_q == $past(tdi_s))
    else $error("bypass stage did not take tdi");
  ir_stable_a: assert property (
    (st_q == ST_SHIFT_IR && trst_s) |=> $stable(ir_q))
    else $error("active instruction moved while shifting");
  ir_update_a: assert property (
    (tck_fall && trst_s && st_q == ST_UPD_IR) |=> ir_q == $past(ir_sh_q))
    else $error("instruction not latched on update");
  ir_shift_a: assert property (
    (tck_rise && st_q == ST_SHIFT_IR) |=>
      ir_sh_q[`JTAP_IR_LEN-2:0] == $past(ir_sh_q[`JTAP_IR_LEN-1:1]))
    else $error("instruction path did not shift");
  tdo_fall_a: assert property (!tck_fall |=> $stable(tdo_q))
    else $error("tdo changed away from a tck fall");
  tdo_drive_a: assert property (
    (tck_fall && in_shift) |=> !tdo_oe_n_q && tdo_q == $past(tdo_d))
    else $error("tdo not driven with shift bit");

  // Reset path and idle
  reset_stay_a: assert property (
    (tck_rise && trst_s && st_q == ST_RESET && tms_s) |=> st_q == ST_RESET)
    else $error("high tms left the reset state");
  idle_stay_a: assert property (
    (tck_rise && trst_s && st_q == ST_IDLE && !tms_s) |=> st_q == ST_IDLE)
    else $error("low tms left idle");
  trst_instr_a: assert property (
    !trst_s |=> ir_q == `JTAP_IR_BYPASS)
    else $error("test reset did not restore bypass");
  ir_reset_a: assert property (
    st_q == ST_RESET |=> ir_q == `JTAP_IR_BYPASS)
    else $error("reset state kept a stale instruction");
  mode_clear_a: assert property (
    st_q == ST_RESET |-> ##2 !test_mode_q)
    else $error("test mode outlived the reset state");

  // Shift paths, edges and pins
  ir_capture_a: assert property (
    (tck_rise && st_q == ST_CAP_IR) |=> ir_sh_q == `JTAP_IR_CAPTURE)
    else $error("instruction capture value missing");
  bypass_cap_a: assert property (
    (tck_rise && sel_byp && st_q == ST_CAP_DR) |=> !byp_q)
    else $error("bypass stage did not capture zero");
  byp_hold_a: assert property (!tck_rise |=> $stable(byp_q))
    else $error("bypass stage moved without tck rise");
  irsh_hold_a: assert property (!tck_rise |=> $stable(ir_sh_q))
    else $error("instruction path moved without tck rise");
  tdo_idle_a: assert property (
    (tck_fall && !in_shift) |=> tdo_oe_n_q)
    else $error("tdo enabled outside a shift state");
  pin_drive_a: assert property (
    is_extest |=> pin_out_q == $past(bsr_upd))
    else $error("pins not driven from the update latch");

  shift_dr_c: cover property (tck_rise && st_q == ST_SHIFT_DR);
  trst_c: cover property (!trst_s && st_q != ST_RESET);
  upd_ir_c: cover property (tck_fall && st_q == ST_UPD_IR);
  tms_reset_c: cover property (tms_cnt_q == `JTAP_RESET_TMS);
  extest_c: cover property (test_mode_q);
endmodule

`default_nettype wire

// *** verif/jtap_probe.sv ***
// Purpose: Behavioural debug probe that drives the test port.
// Assumes: Tasks are called at a falling edge of sys_clk.
// Notes:   One link clock is eight sys_clk periods, 320 ns; tck
//          stands low between frames.
`default_nettype none

module jtap_probe (
  // Clock
  input wire logic sys_clk,
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ==========================================================
  // One link clock, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge sys_clk);
    q = tdo;
    tck = 1'b1;
    repeat (4) @(negedge sys_clk);
    tck = 1'b0;
  endtask

  // ==========================================================
  // Full scan from Idle back to Idle, bits LSB first
  task automatic scan(input logic is_ir, input int n,
    input logic [15:0] din, output logic [15:0] dout,
    output logic oe_bad);
    logic q;
    logic [3:0] head;
    head = is_ir ? 4'hC : 4'h4;
    dout = 16'h0000;
    oe_bad = 1'b0;
    for (int i = is_ir ? 3 : 2; i >= 0; i--) begin
      step(head[i], 1'b0, q);
    end
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      oe_bad = oe_bad | tdo_oe_n;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

`default_nettype wire

// *** verif/jtap_tap_bench.sv ***
// Purpose: Self-checking bench of the test access port.
// Assumes: The probe model paces every link transfer.
// Notes:   Table rows first, then reset paths by hand.
`default_nettype none
`include "jtap_regs.svh"

module jtap_tap_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [3:0] ir;
    logic [15:0] din;
    logic [7:0] pins;
    logic [7:0] core;
    logic [15:0] dout;
    logic [7:0] pout;
  } jtap_row_t;

  logic sys_clk;
  logic rst_n;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe_n;
  logic [7:0] pin_in;
  logic [7:0] core_out;
  logic [7:0] pin_out;
  logic [3:0] instr;
  logic test_mode;
  logic [15:0] got;
  logic bad;
  logic q;
  int err_total = 0;
  int checks = 0;

  jtap_row_t rows [5] = '{
    '{`JTAP_IR_BYPASS, 16'hA5C3, 8'h3C, 8'h96, 16'h4B86, 8'h96},
    '{`JTAP_IR_SAMPLE, 16'h1234, 8'h5A, 8'hC3, 16'hC35A, 8'hC3},
    '{`JTAP_IR_EXTEST, 16'hBE01, 8'hF0, 8'h0F, 16'h0FF0, 8'hBE},
    '{4'h7, 16'h0001, 8'h00, 8'hFF, 16'h0002, 8'hFF},
    '{4'h2, 16'hFFFF, 8'hA5, 8'h5A, 16'hFFFE, 8'h5A}
  };

  jtap_tap u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .instr(instr),
    .test_mode(test_mode)
  );

  jtap_probe u_probe (
    .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n)
  );

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    trst_n = 1'b1;
    pin_in = 8'h00;
    core_out = 8'h00;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(tdo_oe_n, 1'b1);
    check(instr, `JTAP_IR_BYPASS);
    check(test_mode, 1'b0);
    check(pin_out, 8'h00);
    u_probe.step(1'b0, 1'b0, q);
    foreach (rows[k]) begin
      pin_in = rows[k].pins;
      core_out = rows[k].core;
      u_probe.scan(1'b1, `JTAP_IR_LEN, {12'h000, rows[k].ir}, got, bad);
      check(got[3:0], `JTAP_IR_CAPTURE);
      check(instr, rows[k].ir);
      check(test_mode, rows[k].ir == `JTAP_IR_EXTEST);
      check(bad, 1'b0);
      u_probe.scan(1'b0, 16, rows[k].din, got, bad);
      check(got, rows[k].dout);
      check(bad, 1'b0);
      check(tdo_oe_n, 1'b1);
      check(pin_out, rows[k].pout);
    end
    // Five high tms clocks from Shift-DR, four are not enough
    u_probe.scan(1'b1, `JTAP_IR_LEN, {12'h000, `JTAP_IR_EXTEST}, got, bad);
    for (int i = 0; i < 3; i++) begin
      u_probe.step(i == 0, 1'b0, q);
    end
    repeat (4) u_probe.step(1'b1, 1'b0, q);
    check(test_mode, 1'b1);
    u_probe.step(1'b1, 1'b0, q);
    repeat (4) @(negedge sys_clk);
    check(test_mode, 1'b0);
    check(instr, `JTAP_IR_BYPASS);
    u_probe.step(1'b1, 1'b0, q);
    check(instr, `JTAP_IR_BYPASS);
    u_probe.step(1'b0, 1'b0, q);
    // Test reset with the link clock standing still
    u_probe.scan(1'b1, `JTAP_IR_LEN, {12'h000, `JTAP_IR_EXTEST}, got, bad);
    check(test_mode, 1'b1);
    trst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check(test_mode, 1'b0);
    check(instr, `JTAP_IR_BYPASS);
    trst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    u_probe.step(1'b0, 1'b0, q);
    u_probe.scan(1'b0, 16, 16'h8001, got, bad);
    check(got, 16'h0002);
    // Reset in mid-run, with EXTEST loaded and the link at rest
    u_probe.scan(1'b1, `JTAP_IR_LEN, {12'h000, `JTAP_IR_EXTEST}, got, bad);
    check(test_mode, 1'b1);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(tdo, 1'b0);
    check(tdo_oe_n, 1'b1);
    check(pin_out, 8'h00);
    check(instr, `JTAP_IR_BYPASS);
    check(test_mode, 1'b0);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(pin_out, core_out);
    u_probe.step(1'b0, 1'b0, q);
    u_probe.scan(1'b0, 16, 16'h00FF, got, bad);
    check(got, 16'h01FE);
    check(bad, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
